// ### tgu_timer_unit.sv
// Three 16-bit timers (one core, two auxiliary) with APB registers and interrupt.
`timescale 1ns/10ps

module tgu_timer_unit
  import tgu_pkg::*;
(
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [tgu_pkg::TGU_AW-1:0] paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic [tgu_pkg::TGU_NUM-1:0] timer_input_pin,
  input  wire logic [tgu_pkg::TGU_NUM-1:0] direction_pin,
  output logic                           toggle_output_pin,
  output logic                           irq
);
  import tgu_pkg::*;

  // ---------------------------------------------------------------------------
  // Storage.
  // ---------------------------------------------------------------------------
  tgu_ctrl_s            ctrl_reg   [TGU_NUM];  // Per-timer control words.
  logic [TGU_W-1:0]     val_reg    [TGU_NUM];  // Timer values.
  logic [TGU_W-1:0]     val_next   [TGU_NUM];  // Next timer values.
  logic [TGU_NUM-1:0]   flag_reg;              // Sticky request flags, one per timer.
  logic [TGU_NUM-1:0]   flag_next;
  logic [TGU_NUM-1:0]   mask_reg;              // Interrupt mask, same layout.
  logic                 latch_reg;             // Core toggle latch.
  logic                 latch_prev_reg;        // Latch one cycle ago, for edge detection.
  logic [TGU_PSC_W-1:0] psc_reg;               // Free-running prescaler counter.
  logic [2:0]           sync_in_reg  [TGU_NUM]; // Three-stage synchroniser, input pins.
  logic [2:0]           sync_dir_reg [TGU_NUM]; // Three-stage synchroniser, direction pins.
  tgu_pins_s            pin_reg      [TGU_NUM]; // Filtered levels.
  tgu_pins_s            pin_prev_reg [TGU_NUM]; // Filtered levels one cycle ago.
  logic                 pready_reg;
  logic                 pslverr_reg;
  logic [31:0]          prdata_reg;
  logic                 irq_reg;
  logic                 tout_reg;

  // ---------------------------------------------------------------------------
  // APB decode.
  // ---------------------------------------------------------------------------
  // The slave answers with zero wait states: pready is registered from the setup
  // cycle so the first access cycle already completes the transfer.
  wire setup_ph  = psel & ~penable;
  wire access_ok = psel & penable & pready_reg;
  wire wr_go     = access_ok & pwrite & ~pslverr_reg;
  wire hit_stat  = (paddr == TGU_OFS_STATUS);
  wire hit_mask  = (paddr == TGU_OFS_MASK);
  wire hit_state = (paddr == TGU_OFS_STATE);
  logic [TGU_NUM-1:0] hit_ctrl;   // Address selects a control register.
  logic [TGU_NUM-1:0] hit_val;    // Address selects a value register.
  logic [TGU_NUM-1:0] wr_ctrl;    // Write strobes, control registers.
  logic [TGU_NUM-1:0] wr_val;     // Write strobes, value registers.
  wire  any_hit = (|hit_ctrl) | (|hit_val) | hit_stat | hit_mask | hit_state;

  // ---------------------------------------------------------------------------
  // Per-timer event wires.
  // ---------------------------------------------------------------------------
  logic [TGU_NUM-1:0] tick;        // Prescaled tick at this timer's factor.
  logic [TGU_NUM-1:0] pin_rise;    // Filtered input pin edges.
  logic [TGU_NUM-1:0] pin_fall;
  logic [TGU_NUM-1:0] pin_evt;     // Input edge matching edge_sel.
  logic [TGU_NUM-1:0] enc_step;    // Encoder produced a step.
  logic [TGU_NUM-1:0] enc_down;    // Encoder direction of that step.
  logic [TGU_NUM-1:0] cnt_en;      // Timer advances this cycle.
  logic [TGU_NUM-1:0] cnt_dn;      // Direction of that advance.
  logic [TGU_NUM-1:0] wrap;        // Overflow or underflow this cycle.
  logic [TGU_NUM-1:0] reload_req;  // Aux requests a reload of the core.
  logic [TGU_NUM-1:0] capt_req;    // Aux captures the core value.
  logic [TGU_NUM-1:0] load_en;     // Hardware load of this timer.
  logic [TGU_W-1:0]   load_data [TGU_NUM];
  logic [TGU_NUM-1:0] evt;         // Interrupt events.

  wire latch_rise = latch_reg & ~latch_prev_reg;
  wire latch_fall = ~latch_reg & latch_prev_reg;

  // ---------------------------------------------------------------------------
  // Per-timer logic.
  // ---------------------------------------------------------------------------
  for (genvar i = 0; i < TGU_NUM; i++) begin : g_tmr
    tgu_ctrl_s c;
    logic [TGU_PSC_W-1:0] psc_mask;
    logic src_rise;
    logic src_fall;
    logic src_evt;
    logic gate_on;
    logic at_lim;
    logic in_role;
    logic trig_rld;

    assign c = ctrl_reg[i];

    // Register decode for this timer.
    assign hit_ctrl[i] = (paddr == TGU_OFS_CTRL0 + TGU_AW'(i) * TGU_STRIDE);
    assign hit_val[i]  = (paddr == TGU_OFS_VAL0 + TGU_AW'(i) * TGU_STRIDE);
    assign wr_ctrl[i]  = wr_go & hit_ctrl[i];
    assign wr_val[i]   = wr_go & hit_val[i];

    // Factor is 8 shifted left by the select code; a tick falls where all
    // low bits of the shared counter are zero.
    assign psc_mask = (TGU_PSC_BASE << c.isel) - TGU_PSC_ONE;
    assign tick[i]  = ((psc_reg & psc_mask) == '0);

    assign pin_rise[i] = pin_reg[i].inp & ~pin_prev_reg[i].inp;
    assign pin_fall[i] = ~pin_reg[i].inp & pin_prev_reg[i].inp;
    assign pin_evt[i]  = (pin_rise[i] & c.edge_sel[0]) | (pin_fall[i] & c.edge_sel[1]);

    // Aux timers may count toggle latch edges instead of their own pin.
    assign src_rise = (i != TGU_IDX_CORE && c.latch_src) ? latch_rise : pin_rise[i];
    assign src_fall = (i != TGU_IDX_CORE && c.latch_src) ? latch_fall : pin_fall[i];
    assign src_evt  = (src_rise & c.edge_sel[0]) | (src_fall & c.edge_sel[1]);

    assign gate_on = (pin_reg[i].inp == c.gate_high);

    // Quadrature: an A change counts up when A differs from B, a B change
    // counts up when they agree; both changing at once is a lost step.
    wire a_chg = pin_reg[i].inp ^ pin_prev_reg[i].inp;
    wire b_chg = pin_reg[i].dir ^ pin_prev_reg[i].dir;
    assign enc_step[i] = a_chg ^ b_chg;
    assign enc_down[i] = a_chg ? (pin_reg[i].inp == pin_reg[i].dir)
                               : (pin_reg[i].inp != pin_reg[i].dir);

    // Capture and reload roles exist only on the auxiliary timers.
    assign in_role = (i != TGU_IDX_CORE) &&
                     (c.mode == TGU_RELOAD || c.mode == TGU_CAPTURE);

    assign cnt_en[i] = c.run & ~in_role &
                       ((c.mode == TGU_TIMER   & tick[i]) |
                        (c.mode == TGU_GATED   & tick[i] & gate_on) |
                        (c.mode == TGU_COUNTER & src_evt) |
                        (c.mode == TGU_ENCODER & enc_step[i]));

    // Encoder mode takes its own direction; otherwise the pin may override.
    assign cnt_dn[i] = (c.mode == TGU_ENCODER) ? enc_down[i] :
                       (c.dir_ext ? pin_reg[i].dir : c.down);

    assign at_lim  = cnt_dn[i] ? (val_reg[i] == TGU_MINV) : (val_reg[i] == TGU_MAXV);
    assign wrap[i] = cnt_en[i] & at_lim;

    assign trig_rld = ((c.reload_src == TGU_RLD_LRISE) & latch_rise) |
                      ((c.reload_src == TGU_RLD_LFALL) & latch_fall) |
                      ((c.reload_src == TGU_RLD_PIN)   & pin_evt[i]);
    assign reload_req[i] = (i != TGU_IDX_CORE) && c.mode == TGU_RELOAD && trig_rld;
    assign capt_req[i]   = (i != TGU_IDX_CORE) && c.mode == TGU_CAPTURE && pin_evt[i];

    if (i == TGU_IDX_CORE) begin : g_core
      // Each aux reacts to its own latch edge, so two aux timers on opposite
      // edges take turns; if both fire together, aux A wins.
      assign load_en[i]   = reload_req[TGU_IDX_A] | reload_req[TGU_IDX_B];
      assign load_data[i] = reload_req[TGU_IDX_A] ? val_reg[TGU_IDX_A] : val_reg[TGU_IDX_B];
      assign evt[i]       = wrap[i];
    end else begin : g_aux
      assign load_en[i]   = capt_req[i];
      assign load_data[i] = val_reg[TGU_IDX_CORE];
      assign evt[i]       = wrap[i] | capt_req[i] | reload_req[i];
    end

    // Software write beats a hardware load, which beats counting.
    assign val_next[i] = wr_val[i]  ? pwdata[TGU_W-1:0] :
                         load_en[i] ? load_data[i] :
                         cnt_en[i]  ? (cnt_dn[i] ? val_reg[i] - TGU_STEP
                                                 : val_reg[i] + TGU_STEP) :
                         val_reg[i];

    // Pin synchronisers: the first stage feeds only the second; a new level
    // is accepted once the second and third stages agree.
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        sync_in_reg[i]  <= 3'h0;
        sync_dir_reg[i] <= 3'h0;
      end else begin
        sync_in_reg[i]  <= {sync_in_reg[i][1:0], timer_input_pin[i]};
        sync_dir_reg[i] <= {sync_dir_reg[i][1:0], direction_pin[i]};
      end
    end

    // Filtered levels and their one-cycle history.
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        pin_reg[i]      <= '0;
        pin_prev_reg[i] <= '0;
      end else begin
        if (sync_in_reg[i][1] == sync_in_reg[i][2]) begin
          pin_reg[i].inp <= sync_in_reg[i][2];
        end
        if (sync_dir_reg[i][1] == sync_dir_reg[i][2]) begin
          pin_reg[i].dir <= sync_dir_reg[i][2];
        end
        pin_prev_reg[i] <= pin_reg[i];
      end
    end

    // Control and value registers of this timer.
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        ctrl_reg[i] <= tgu_ctrl_s'(TGU_CTRL_RST);
        val_reg[i]  <= TGU_MINV;
      end else begin
        if (wr_ctrl[i]) begin
          ctrl_reg[i] <= tgu_ctrl_s'(pwdata[15:0]);
        end
        val_reg[i] <= val_next[i];
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Flags and interrupt.
  // ---------------------------------------------------------------------------
  // A new event in the clearing cycle keeps its flag set.
  assign flag_next = (flag_reg & ~(wr_go & hit_stat ? pwdata[TGU_NUM-1:0] : '0)) |
                     evt;

  // Prescaler counter, toggle latch and flag state.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      psc_reg        <= '0;
      latch_reg      <= 1'b0;
      latch_prev_reg <= 1'b0;
      flag_reg       <= TGU_FLAG_RST;
      mask_reg       <= TGU_FLAG_RST;
    end else begin
      psc_reg        <= psc_reg + TGU_PSC_ONE;
      latch_reg      <= latch_reg ^ wrap[TGU_IDX_CORE];
      latch_prev_reg <= latch_reg;
      flag_reg       <= flag_next;
      if (wr_go && hit_mask) begin
        mask_reg <= pwdata[TGU_NUM-1:0];
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Read mux and registered outputs.
  // ---------------------------------------------------------------------------
  logic [31:0] rd_mux;  // Read data selected by address.
  always_comb begin
    rd_mux = '0;
    for (int k = 0; k < TGU_NUM; k++) begin
      if (hit_ctrl[k]) begin
        rd_mux = {16'h0000, ctrl_reg[k]};
      end
      if (hit_val[k]) begin
        rd_mux = {16'h0000, val_reg[k]};
      end
    end
    if (hit_stat) begin
      rd_mux = {29'h0, flag_reg};
    end
    if (hit_mask) begin
      rd_mux = {29'h0, mask_reg};
    end
    if (hit_state) begin
      rd_mux = {25'h0, pin_reg[2], pin_reg[1], pin_reg[0], latch_reg};
    end
  end

  // Bus answer is prepared in the setup cycle; irq lags a flag by one cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= '0;
      irq_reg     <= 1'b0;
      tout_reg    <= 1'b0;
    end else begin
      pready_reg  <= setup_ph;
      pslverr_reg <= setup_ph & ~any_hit;
      prdata_reg  <= setup_ph & ~pwrite ? rd_mux : '0;
      irq_reg     <= |(flag_reg & mask_reg);
      tout_reg    <= latch_reg & ctrl_reg[TGU_IDX_CORE].out_en;
    end
  end

  assign prdata            = prdata_reg;
  assign pready            = pready_reg;
  assign pslverr           = pslverr_reg;
  assign irq               = irq_reg;
  assign toggle_output_pin = tout_reg;

endmodule : tgu_timer_unit

// ### tgu_pkg.sv
// Shared constants, register map, field layout and types of the three-timer unit.
package tgu_pkg;

  // ---------------------------------------------------------------------------
  // Sizes.
  // ---------------------------------------------------------------------------
  localparam int TGU_NUM      = 3;      // Timers in the unit.
  localparam int TGU_W        = 16;     // Width of each timer.
  localparam int TGU_AW       = 8;      // APB address width.
  localparam int TGU_PSC_W    = 11;     // Free-running prescaler counter width.
  localparam int TGU_IDX_A    = 0;      // Auxiliary timer A.
  localparam int TGU_IDX_CORE = 1;      // Core timer.
  localparam int TGU_IDX_B    = 2;      // Auxiliary timer B.

  // ---------------------------------------------------------------------------
  // Register byte addresses.
  // ---------------------------------------------------------------------------
  localparam logic [TGU_AW-1:0] TGU_OFS_CTRL0  = 8'h00;  // Control of aux timer A.
  localparam logic [TGU_AW-1:0] TGU_OFS_VAL0   = 8'h0C;  // Value of aux timer A.
  localparam logic [TGU_AW-1:0] TGU_OFS_STATUS = 8'h18;  // Sticky event flags, write one to clear.
  localparam logic [TGU_AW-1:0] TGU_OFS_MASK   = 8'h1C;  // Interrupt mask.
  localparam logic [TGU_AW-1:0] TGU_OFS_STATE  = 8'h20;  // Live latch and pin levels.
  localparam logic [TGU_AW-1:0] TGU_STRIDE     = 8'h04;  // Spacing of per-timer registers.

  // ---------------------------------------------------------------------------
  // Constants used by the logic.
  // ---------------------------------------------------------------------------
  localparam logic [TGU_PSC_W-1:0] TGU_PSC_BASE = 11'h008;  // Factor for select code 000b.
  localparam logic [TGU_PSC_W-1:0] TGU_PSC_ONE  = 11'h001;
  localparam logic [TGU_W-1:0]     TGU_MAXV     = 16'hFFFF;
  localparam logic [TGU_W-1:0]     TGU_MINV     = 16'h0000;
  localparam logic [TGU_W-1:0]     TGU_STEP     = 16'h0001;
  localparam logic [15:0]          TGU_CTRL_RST = 16'h0000;
  localparam logic [2:0]           TGU_FLAG_RST = 3'h0;

  // Edge selection codes for pin or latch triggers.
  localparam logic [1:0] TGU_EDGE_RISE = 2'h1;
  localparam logic [1:0] TGU_EDGE_FALL = 2'h2;
  localparam logic [1:0] TGU_EDGE_BOTH = 2'h3;

  // Reload trigger source codes.
  localparam logic [1:0] TGU_RLD_LRISE = 2'h1;  // Toggle latch goes 0 to 1.
  localparam logic [1:0] TGU_RLD_LFALL = 2'h2;  // Toggle latch goes 1 to 0.
  localparam logic [1:0] TGU_RLD_PIN   = 2'h3;  // Input pin edge per edge_sel.

  // ---------------------------------------------------------------------------
  // Types.
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {
    TGU_TIMER, TGU_GATED, TGU_COUNTER, TGU_ENCODER, TGU_RELOAD, TGU_CAPTURE
  } tgu_mode_e;

  // Control word of one timer, low 16 bits of its control register.
  typedef struct packed {
    logic       out_en;      // Core only: drive the latch to the output pin.
    logic [1:0] reload_src;  // Aux reload role: trigger source.
    logic       latch_src;   // Aux counter mode: count latch edges instead of the pin.
    logic       gate_high;   // Gated mode: 1 counts while pin high, 0 while low.
    logic [1:0] edge_sel;    // Counter and pin-trigger edge selection.
    logic       dir_ext;     // Direction pin overrides the software direction.
    logic       down;        // Software direction, 1 counts down.
    logic       run;         // Timer runs.
    tgu_mode_e  mode;        // Operating mode.
    logic [2:0] isel;        // Prescaler select.
  } tgu_ctrl_s;

  // Filtered pin levels of one timer.
  typedef struct packed {
    logic inp;  // Gate, count or encoder A input.
    logic dir;  // Direction or encoder B input.
  } tgu_pins_s;

endpackage : tgu_pkg

// ### tgu_pins_model.sv
// Model of the pin-side party: gate, count, direction and encoder signals.
`timescale 1ns/10ps

module tgu_pins_model (
  input  wire logic       pclk,
  output logic      [2:0] timer_input_pin,
  output logic      [2:0] direction_pin
);
  // Both pin groups start low; the unit filters them, so edges stay 4 cycles apart.
  initial begin
    timer_input_pin = 3'h0;
    direction_pin   = 3'h0;
  end

  // Sets a static level; d selects the direction pin of timer i.
  task automatic set_lvl(input logic d, input int i, input logic v);
    @(posedge pclk);
    if (d) begin
      direction_pin <= v ? (direction_pin | (3'h1 << i)) : (direction_pin & ~(3'h1 << i));
    end else begin
      timer_input_pin <= v ? (timer_input_pin | (3'h1 << i)) : (timer_input_pin & ~(3'h1 << i));
    end
    repeat (8) @(posedge pclk);
  endtask : set_lvl

  // One full pulse: a rising and a falling edge, each held long enough to pass the filter.
  task automatic pulse(input int i);
    @(posedge pclk);
    timer_input_pin <= timer_input_pin ^ (3'h1 << i);
    repeat (4) @(posedge pclk);
    timer_input_pin <= timer_input_pin ^ (3'h1 << i);
    repeat (4) @(posedge pclk);
  endtask : pulse

  // One quadrature step; only one of the two lines moves, as a real sensor does.
  task automatic step(input int i, input logic up);
    logic same;
    same = (timer_input_pin[i] == direction_pin[i]);
    @(posedge pclk);
    if (same == up) begin
      timer_input_pin <= timer_input_pin ^ (3'h1 << i);
    end else begin
      direction_pin <= direction_pin ^ (3'h1 << i);
    end
    repeat (4) @(posedge pclk);
  endtask : step
endmodule : tgu_pins_model

// ### tgu_timer_unit_chk.sv
// Concurrent checks on the ports of the three-timer unit.
`timescale 1ns/10ps

module tgu_timer_unit_chk
  import tgu_pkg::*;
(
  input wire logic                        pclk,
  input wire logic                        presetn,
  input wire logic                        psel,
  input wire logic                        penable,
  input wire logic                        pwrite,
  input wire logic [tgu_pkg::TGU_AW-1:0]  paddr,
  input wire logic [31:0]                 prdata,
  input wire logic                        pready,
  input wire logic                        pslverr,
  input wire logic                        toggle_output_pin,
  input wire logic                        irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Zero wait states: the access cycle always carries pready for exactly one cycle.
  a_ready_after_setup: assert property (psel && !penable |=> pready) else $error("no pready");
  a_ready_one_cycle: assert property (pready |=> !pready) else $error("pready too long");
  a_ready_in_access: assert property (pready |-> psel && penable) else $error("stray pready");
  // Unmapped or misaligned addresses are refused; mapped ones never are.
  a_err_unmapped: assert property (pready && (paddr > TGU_OFS_STATE || paddr[1:0] != 2'h0)
    |-> pslverr) else $error("no pslverr");
  a_ok_mapped: assert property (pready && paddr <= TGU_OFS_STATE && paddr[1:0] == 2'h0
    |-> !pslverr) else $error("false pslverr");
  a_rdata_idle_zero: assert property (!pready || pwrite || pslverr |-> prdata == 32'h0)
    else $error("prdata not zero");
  // Flags are sticky and the mask moves only by a write, so irq holds while the bus rests.
  a_irq_sticky_hold: assert property ((irq && !psel) ##1 (irq && !psel) |=> irq)
    else $error("irq dropped");
  // Prescaled ticks are at least 8 cycles apart, so in timer and gated modes the latch cannot flip twice quickly.
  a_latch_flip_spacing: assert property ($changed(toggle_output_pin) |=>
    $stable(toggle_output_pin) [*2]) else $error("latch flips too fast");

  c_irq: cover property ($rose(irq));
  c_latch: cover property ($rose(toggle_output_pin));
  c_refused: cover property (pslverr);
endmodule : tgu_timer_unit_chk

bind tgu_timer_unit tgu_timer_unit_chk tgu_timer_unit_chk_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .toggle_output_pin(toggle_output_pin), .irq(irq)
);

// ### tgu_timer_unit_tb_top.sv
// Self-checking bench for the three-timer unit with its pin-side model.
`timescale 1ns/10ps

module tgu_timer_unit_tb_top;
  import tgu_pkg::*;
  // ---------------------------------------------------------------------------
  // Signals and counters.
  // ---------------------------------------------------------------------------
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic        toggle_output_pin, irq;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rv;
  logic [2:0]  tin, dir;
  int          n_fail, tests_run;

  tgu_timer_unit tgu_timer_unit_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .timer_input_pin(tin), .direction_pin(dir),
    .toggle_output_pin(toggle_output_pin), .irq(irq));
  tgu_pins_model tgu_pins_model_i (.pclk(pclk), .timer_input_pin(tin), .direction_pin(dir));

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // ---------------------------------------------------------------------------
  // Bus and comparison tasks.
  // ---------------------------------------------------------------------------
  // One APB transfer; the request holds until pready is sampled, so waits never assume latency.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(rv, e);
  endtask : rd

  // Runs a timer for exactly n cycles: both writes take 3 edges, so their effects are n apart.
  task automatic run_win(input logic [7:0] a, input logic [31:0] c, input int n);
    xfer(1'b1, a, c);
    repeat (n - 3) @(posedge pclk);
    xfer(1'b1, a, c & ~32'h40);
  endtask : run_win

  // ---------------------------------------------------------------------------
  // Scenarios.
  // ---------------------------------------------------------------------------
  task automatic t_regs();
    rd(TGU_OFS_CTRL0, 32'h0);
    rd(8'h10, 32'h0);
    rd(TGU_OFS_STATUS, 32'h0);
    rd(TGU_OFS_MASK, 32'h0);
    xfer(1'b1, 8'h40, 32'h1);
    chk(err, 1'b1);
    rd(8'h02, 32'h0);
    chk(err, 1'b1);
    $display("test regs done");
  endtask : t_regs

  // Two ticks per window at every select code, on the core timer.
  task automatic t_presc();
    for (int i = 0; i < 8; i++) begin
      xfer(1'b1, 8'h10, 32'h0);
      run_win(8'h04, 32'h40 | 32'(i), 16 << i);
      rd(8'h10, 32'h2);
    end
    $display("test prescaler done");
  endtask : t_presc

  // Software down, then pin-forced down with software set to up.
  task automatic t_dir();
    xfer(1'b1, 8'h10, 32'h5);
    run_win(8'h04, 32'hC0, 16);
    rd(8'h10, 32'h3);
    tgu_pins_model_i.set_lvl(1'b1, 1, 1'b1);
    xfer(1'b1, 8'h10, 32'h5);
    run_win(8'h04, 32'h140, 16);
    rd(8'h10, 32'h3);
    tgu_pins_model_i.set_lvl(1'b1, 1, 1'b0);
    $display("test direction done");
  endtask : t_dir

  // Aux A gated high: closed gate holds, open gate counts prescaled ticks.
  task automatic t_gated();
    xfer(1'b1, 8'h0C, 32'h0);
    run_win(8'h00, 32'h848, 32);
    rd(8'h0C, 32'h0);
    tgu_pins_model_i.set_lvl(1'b0, 0, 1'b1);
    run_win(8'h00, 32'h848, 32);
    rd(8'h0C, 32'h4);
    tgu_pins_model_i.set_lvl(1'b0, 0, 1'b0);
    $display("test gated done");
  endtask : t_gated

  // Aux B counts rising edges, then both edges.
  task automatic t_count();
    xfer(1'b1, 8'h14, 32'h0);
    xfer(1'b1, 8'h08, 32'h250);
    repeat (5) tgu_pins_model_i.pulse(2);
    rd(8'h14, 32'h5);
    xfer(1'b1, 8'h08, 32'h650);
    repeat (3) tgu_pins_model_i.pulse(2);
    rd(8'h14, 32'hB);
    xfer(1'b1, 8'h08, 32'h0);
    $display("test counter done");
  endtask : t_count

  task automatic t_enc();
    xfer(1'b1, 8'h10, 32'h0);
    xfer(1'b1, 8'h04, 32'h58);
    repeat (4) tgu_pins_model_i.step(1, 1'b1);
    rd(8'h10, 32'h4);
    repeat (2) tgu_pins_model_i.step(1, 1'b0);
    rd(8'h10, 32'h2);
    xfer(1'b1, 8'h04, 32'h0);
    $display("test encoder done");
  endtask : t_enc

  // Core wraps: latch, pin, flag, then mask and write-one-clear.
  task automatic t_ovf();
    xfer(1'b1, TGU_OFS_STATUS, 32'h7);
    xfer(1'b1, TGU_OFS_MASK, 32'h2);
    // Aux B counts rising latch edges meanwhile, so the chain is exercised too.
    xfer(1'b1, 8'h08, 32'h1250);
    xfer(1'b1, 8'h10, 32'hFFFE);
    xfer(1'b1, 8'h04, 32'h8040);
    repeat (40) @(posedge pclk);
    xfer(1'b1, 8'h04, 32'h8000);
    rd(TGU_OFS_STATUS, 32'h2);
    chk(irq, 1'b1);
    chk(toggle_output_pin, 1'b1);
    rd(8'h14, 32'hC);
    rd(TGU_OFS_STATE, 32'h19);
    xfer(1'b1, TGU_OFS_MASK, 32'h0);
    repeat (2) @(posedge pclk);
    chk(irq, 1'b0);
    xfer(1'b1, TGU_OFS_MASK, 32'h2);
    xfer(1'b1, TGU_OFS_STATUS, 32'h2);
    repeat (2) @(posedge pclk);
    chk(irq, 1'b0);
    rd(TGU_OFS_STATUS, 32'h0);
    $display("test overflow done");
  endtask : t_ovf

  // Aux A in capture role with run set: it copies the core and never counts.
  task automatic t_cap();
    xfer(1'b1, 8'h10, 32'h1234);
    xfer(1'b1, 8'h00, 32'h268);
    tgu_pins_model_i.pulse(0);
    repeat (40) @(posedge pclk);
    rd(8'h0C, 32'h1234);
    rd(TGU_OFS_STATUS, 32'h1);
    xfer(1'b1, 8'h00, 32'h0);
    xfer(1'b1, TGU_OFS_STATUS, 32'h7);
    $display("test capture done");
  endtask : t_cap

  // Alternating reloads: high time from aux A (16 ticks), low time from aux B (8 ticks).
  task automatic t_pwm();
    int hi;
    int lo;
    xfer(1'b1, 8'h0C, 32'hFFF0);
    xfer(1'b1, 8'h14, 32'hFFF8);
    xfer(1'b1, 8'h00, 32'h2020);
    xfer(1'b1, 8'h08, 32'h4020);
    xfer(1'b1, 8'h10, 32'hFFFE);
    xfer(1'b1, 8'h04, 32'h8040);
    repeat (300) @(posedge pclk);
    // Let any high phase already under way pass, so both counts cover whole phases.
    while (toggle_output_pin === 1'b1) @(posedge pclk);
    while (toggle_output_pin !== 1'b1) @(posedge pclk);
    hi = 0;
    lo = 0;
    while (toggle_output_pin === 1'b1) begin
      @(posedge pclk);
      hi++;
    end
    while (toggle_output_pin === 1'b0) begin
      @(posedge pclk);
      lo++;
    end
    chk(32'(hi), 32'h80);
    chk(32'(lo), 32'h40);
    rd(TGU_OFS_STATUS, 32'h7);
    xfer(1'b1, 8'h04, 32'h0);
    $display("test pwm done");
  endtask : t_pwm

  // ---------------------------------------------------------------------------
  // Verdict, main sequence and watchdog.
  // ---------------------------------------------------------------------------
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : print_verdict

  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    n_fail = 0;
    tests_run = 0;
    presetn = 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_presc();
    t_dir();
    t_gated();
    t_count();
    t_enc();
    t_ovf();
    t_cap();
    t_pwm();
    print_verdict();
  end

  // The whole run needs about 5240 cycles; a hang is cut off well beyond that.
  initial begin
    repeat (40000) @(posedge pclk);
    n_fail++;
    print_verdict();
  end
endmodule : tgu_timer_unit_tb_top
